// ### design/i2t_params.svh
/*
 Constants of the I2C target that gives a host access to the register bank.
 Assumes inclusion by i2t_target.sv only, not by i2t_pkg.sv.
*/
`ifndef I2T_PARAMS_SVH
`define I2T_PARAMS_SVH
`define I2T_ADDR_BASE 7'h08
`define I2T_STRAP_GND 3'h0
`define I2T_STRAP_20K 3'h1
`define I2T_STRAP_30K 3'h2
`define I2T_STRAP_40K 3'h3
`define I2T_STRAP_50K 3'h4
`define I2T_STRAP_OPEN 3'h5
`define I2T_BITS_BYTE 4'h8
`define I2T_BIT_FIFTH 4'h4
`define I2T_PTR_RESET 8'h00
`define I2T_RW_POS 0
`endif

// ### design/i2t_pkg.sv
/*
 Types of the I2C target: protocol states and clock roles.
 Assumes i2t_params.svh sits beside it.
*/
package i2t_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_WPTR = 3'b010,
      ST_WDAT = 3'b011,
      ST_RDAT = 3'b100,
      ST_SKIP = 3'b101
   } i2t_state_t;

   typedef enum logic [1:0] {
      ROLE_ALONE = 2'b00,
      ROLE_SLAVE_RISE = 2'b01,
      ROLE_SLAVE_FALL = 2'b10,
      ROLE_MASTER = 2'b11
   } i2t_role_t;
endpackage : i2t_pkg

// ### design/i2t_target.sv
/*
 I2C target giving an external host read and write access to the register
 bank through an auto-incrementing eight bit index.
 Assumes SCL, SDA, bias power good and the strap code are asynchronous to
 ref_clk; the register bank answers reg_rdata in the same cycle as ptr.
*/
`include "i2t_params.svh"

module i2t_target
   import i2t_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic bias_power_good,
   input wire logic [2:0] strap_code,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic [7:0] reg_ptr,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_valid,
   output logic reg_we,
   output logic [7:0] reg_waddr,
   output logic [7:0] reg_wdata,
   output logic [6:0] target_addr,
   output logic [1:0] clk_role,
   output logic strap_done
);

   // Strap to clock role; codes above open read as open
   function automatic i2t_role_t role_of(input logic [2:0] code);
      case (code)
         `I2T_STRAP_GND: role_of = ROLE_ALONE;
         `I2T_STRAP_20K, `I2T_STRAP_40K: role_of = ROLE_SLAVE_RISE;
         `I2T_STRAP_30K, `I2T_STRAP_50K: role_of = ROLE_SLAVE_FALL;
         default: role_of = ROLE_MASTER;
      endcase
   endfunction
   // Strap to address; resistor order maps onto address order
   function automatic logic [6:0] addr_of(input logic [2:0] code);
      logic [2:0] c;
      c = (code > `I2T_STRAP_OPEN) ? `I2T_STRAP_OPEN : code;
      addr_of = `I2T_ADDR_BASE + {4'h0, c};
   endfunction
   // Two-stage synchronisers plus a third stage for edge detection
   logic scl_s1_q, scl_s2_q, scl_p_q;
   logic sda_s1_q, sda_s2_q, sda_p_q;
   logic pg_s1_q, pg_s2_q;
   logic [2:0] strap_s1_q, strap_s2_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_p_q <= 1'b1;
         pg_s1_q <= 1'b0;
         pg_s2_q <= 1'b0;
         strap_s1_q <= 3'h0;
         strap_s2_q <= 3'h0;
      end else begin
         scl_s1_q <= scl_i;
         scl_s2_q <= scl_s1_q;
         scl_p_q <= scl_s2_q;
         sda_s1_q <= sda_i;
         sda_s2_q <= sda_s1_q;
         sda_p_q <= sda_s2_q;
         pg_s1_q <= bias_power_good;
         pg_s2_q <= pg_s1_q;
         strap_s1_q <= strap_code;
         strap_s2_q <= strap_s1_q;
      end
   end
   // Bus events seen on the synchronised lines
   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise = scl_s2_q & ~scl_p_q;
   assign scl_fall = ~scl_s2_q & scl_p_q;
   assign start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
   assign stop_det = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
   // Strap latch: caught once when bias first reports good
   logic [6:0] addr_q, addr_d;
   logic [1:0] role_q, role_d;
   logic done_q, done_d;
   always_comb begin
      addr_d = addr_q;
      role_d = role_q;
      done_d = done_q;
      if (pg_s2_q && !done_q) begin
         addr_d = addr_of(strap_s2_q);
         role_d = role_of(strap_s2_q);
         done_d = 1'b1;
      end
   end
   // Only a reset (power-up) clears the latch, so later glitches are ignored
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         addr_q <= `I2T_ADDR_BASE;
         role_q <= ROLE_ALONE;
         done_q <= 1'b0;
      end else begin
         addr_q <= addr_d;
         role_q <= role_d;
         done_q <= done_d;
      end
   end
   // Protocol state
   i2t_state_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic ack_q, ack_d;
   logic nack_q, nack_d;
   logic [7:0] sh_q, sh_d;
   logic [7:0] ptr_q, ptr_d;
   logic oe_q, oe_d;
   logic we_q, we_d;
   logic [7:0] wdat_q, wdat_d;
   logic [7:0] wadr_q, wadr_d;
   logic [7:0] rd_byte;
   // Unimplemented locations read as zero
   assign rd_byte = reg_valid ? reg_rdata : 8'h00;
   // Next-state logic; START and STOP win over any bit activity
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      ack_d = ack_q;
      nack_d = nack_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      oe_d = oe_q;
      we_d = 1'b0;
      wdat_d = wdat_q;
      wadr_d = wadr_q;
      if (!pg_s2_q) begin
         st_d = ST_IDLE;
         cnt_d = 4'h0;
         ack_d = 1'b0;
         oe_d = 1'b0;
      end else if (start_det) begin
         st_d = ST_ADDR;
         cnt_d = 4'h0;
         ack_d = 1'b0;
         oe_d = 1'b0;
      end else if (stop_det) begin
         st_d = ST_IDLE;
         cnt_d = 4'h0;
         ack_d = 1'b0;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            ST_ADDR, ST_WPTR, ST_WDAT: begin
               if (scl_rise && !ack_q && cnt_q != `I2T_BITS_BYTE) begin
                  sh_d = {sh_q[6:0], sda_s2_q};
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall && !ack_q &&
                            cnt_q == `I2T_BITS_BYTE) begin
                  ack_d = 1'b1;
                  oe_d = 1'b1;
                  if (st_q == ST_ADDR && sh_q[7:1] != addr_q) begin
                     // Other target: release and ignore till START or STOP
                     st_d = ST_SKIP;
                     ack_d = 1'b0;
                     oe_d = 1'b0;
                  end else if (st_q == ST_WPTR) begin
                     ptr_d = sh_q;
                  end else if (st_q == ST_WDAT) begin
                     we_d = 1'b1;
                     wdat_d = sh_q;
                     wadr_d = ptr_q;
                     ptr_d = ptr_q + 8'h01;
                  end
               end else if (scl_fall && ack_q) begin
                  ack_d = 1'b0;
                  cnt_d = 4'h0;
                  oe_d = 1'b0;
                  if (st_q == ST_ADDR && sh_q[`I2T_RW_POS]) begin
                     // First data bit goes out as the ACK clock ends
                     st_d = ST_RDAT;
                     sh_d = rd_byte;
                     oe_d = ~rd_byte[7];
                  end else if (st_q == ST_ADDR) begin
                     st_d = ST_WPTR;
                  end else begin
                     st_d = ST_WDAT;
                  end
               end
            end
            ST_RDAT: begin
               if (scl_rise && !ack_q) begin
                  cnt_d = cnt_q + 4'h1;
                  // Advanced on the fifth clock, whether or not byte ends
                  if (cnt_q == `I2T_BIT_FIFTH) begin
                     ptr_d = ptr_q + 8'h01;
                  end
               end else if (scl_fall && !ack_q &&
                            cnt_q != `I2T_BITS_BYTE) begin
                  sh_d = {sh_q[6:0], 1'b0};
                  oe_d = ~sh_q[6];
               end else if (scl_fall && !ack_q) begin
                  ack_d = 1'b1; // Release for the host's ACK
                  oe_d = 1'b0;
               end else if (scl_rise && ack_q) begin
                  nack_d = sda_s2_q;
               end else if (scl_fall && ack_q) begin
                  ack_d = 1'b0;
                  cnt_d = 4'h0;
                  if (nack_q) begin
                     st_d = ST_SKIP;
                     oe_d = 1'b0;
                  end else begin
                     sh_d = rd_byte;
                     oe_d = ~rd_byte[7];
                  end
               end
            end
            default: begin
               oe_d = 1'b0;
            end
         endcase
      end
   end
   // Index survives every transaction; only reset clears it
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
         nack_q <= 1'b0;
         sh_q <= 8'h00;
         ptr_q <= `I2T_PTR_RESET;
         oe_q <= 1'b0;
         we_q <= 1'b0;
         wdat_q <= 8'h00;
         wadr_q <= 8'h00;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         ack_q <= ack_d;
         nack_q <= nack_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         oe_q <= oe_d;
         we_q <= we_d;
         wdat_q <= wdat_d;
         wadr_q <= wadr_d;
      end
   end
   // Open-drain pins: data level is always low, only the enable moves
   logic sda_o_q, scl_o_q, scl_oe_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sda_o_q <= 1'b0;
         scl_o_q <= 1'b0;
         scl_oe_q <= 1'b0;
      end else begin
         sda_o_q <= 1'b0;
         scl_o_q <= 1'b0;
         scl_oe_q <= 1'b0; // No clock stretching
      end
   end
   assign sda_o = sda_o_q;
   assign sda_oe = oe_q;
   assign scl_o = scl_o_q;
   assign scl_oe = scl_oe_q;
   assign reg_ptr = ptr_q;
   assign reg_we = we_q;
   assign reg_waddr = wadr_q;
   assign reg_wdata = wdat_q;
   assign target_addr = addr_q;
   assign clk_role = role_q;
   assign strap_done = done_q;
   // Checks on the behaviour above
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   property p_quiet_unpowered;
      !pg_s2_q |=> !oe_q && st_q == ST_IDLE;
   endproperty
   a_quiet_unpowered: assert property (p_quiet_unpowered)
      else $error("bus driven without bias power good");
   property p_stop_releases;
      stop_det && pg_s2_q |=> !oe_q ##1 !oe_q;
   endproperty
   a_stop_releases: assert property (p_stop_releases)
      else $error("SDA still pulled after STOP");
   property p_never_high;
      sda_o_q == 1'b0 && !scl_oe_q;
   endproperty
   a_never_high: assert property (p_never_high)
      else $error("pin driven high or SCL pulled");
   property p_ack_own_addr;
      st_q == ST_ADDR && ack_q |-> oe_q && sh_q[7:1] == addr_q;
   endproperty
   a_ack_own_addr: assert property (p_ack_own_addr)
      else $error("acknowledge of a foreign address");
   // Address offset from the base is the strap code capped at open (5), cut to three bits
   property p_role_matches;
      done_q |-> role_q == role_of(3'(addr_q - `I2T_ADDR_BASE));
   endproperty
   a_role_matches: assert property (p_role_matches)
      else $error("clock role disagrees with address");
   property p_ptr_load;
      st_q == ST_WPTR && scl_fall && !ack_q && cnt_q == `I2T_BITS_BYTE
         && pg_s2_q && !start_det && !stop_det |=> ptr_q == $past(sh_q);
   endproperty
   a_ptr_load: assert property (p_ptr_load)
      else $error("index not loaded at acknowledge");
   property p_write_inc;
      we_q |-> ptr_q == wadr_q + 8'h01 && st_q == ST_WDAT && ack_q;
   endproperty
   a_write_inc: assert property (p_write_inc)
      else $error("index not advanced after write");
   property p_read_inc;
      st_q == ST_RDAT && scl_rise && !ack_q && cnt_q == `I2T_BIT_FIFTH
         && pg_s2_q && !start_det && !stop_det
         |=> ptr_q == $past(ptr_q) + 8'h01 && cnt_q == 4'h5;
   endproperty
   a_read_inc: assert property (p_read_inc)
      else $error("index not advanced on fifth clock");
   property p_idle_keeps;
      st_q inside {ST_IDLE, ST_SKIP} && $past(st_q) inside {ST_IDLE, ST_SKIP}
         |-> ptr_q == $past(ptr_q);
   endproperty
   a_idle_keeps: assert property (p_idle_keeps)
      else $error("index moved while not addressed");
   property p_strap_held;
      done_q && $past(done_q) |-> $stable(addr_q) && $stable(role_q);
   endproperty
   a_strap_held: assert property (p_strap_held)
      else $error("strap result changed after start-up");
endmodule // i2t_target

// ### test/i2t_host_model.sv
/*
 Host controller model that drives SCL and SDA as an open-drain master.
 Assumes the bench resolves both wires with pull-ups; SCL idles high.
*/
module i2t_host_model (
   input wire logic ref_clk,
   input wire logic sda_line,
   output logic scl_low,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 100ps;

   // Released lines at time zero: bus idle
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // One 16 clock SCL period; data set 6 clocks before the rise
   task automatic clk_bit(input logic b, output logic s);
      tick(2);
      sda_low <= ~b;
      tick(6);
      scl_low <= 1'b0;
      tick(4);
      s = sda_line;
      tick(4);
      scl_low <= 1'b1;
   endtask

   // Also a repeated START when entered with SCL low
   task automatic bus_start();
      tick(2);
      sda_low <= 1'b0;
      tick(4);
      scl_low <= 1'b0;
      tick(8);
      sda_low <= 1'b1;
      tick(8);
      scl_low <= 1'b1;
   endtask

   // Leaves SCL high and SDA released, so the clock stands still
   task automatic bus_stop();
      tick(2);
      sda_low <= 1'b1;
      tick(4);
      scl_low <= 1'b0;
      tick(8);
      sda_low <= 1'b0;
      tick(8);
   endtask

   // MSB first, then the target's acknowledge slot
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk_bit(b[i], s);
      clk_bit(1'b1, s);
      ack = ~s;
   endtask

   // ACK to ask for more, NACK on the last byte
   task automatic recv_byte(input logic more, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk_bit(1'b1, b[i]);
      clk_bit(~more, s);
   endtask
endmodule // i2t_host_model

// ### test/test_i2t_target.sv
/*
 Self-checking bench of the I2C target with a small register bank.
 Assumes i2t_pkg, i2t_target and i2t_host_model are compiled first.
*/
`define CHK(nm, e, g) \
   begin \
      n_compared++; \
      if ((g) !== (e)) begin \
         n_errors++; \
         $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
      end \
   end

module test_i2t_target;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [6:0] ADDR = 7'h0A;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic bias_power_good = 1'b0;
   logic [2:0] strap_code = 3'h0;
   logic scl_o, scl_oe, sda_o, sda_oe, reg_we, strap_done;
   logic [7:0] reg_ptr, reg_waddr, reg_wdata;
   logic [7:0] mem [256];
   logic [6:0] target_addr;
   logic [1:0] clk_role;
   logic scl_low, sda_low;
   logic bad_drive = 1'b0;
   logic [15:0] wq [$];
   int n_errors = 0;
   int n_compared = 0;
   // Pull-ups: a released wire reads high
   wire logic scl_line = ~(scl_low | scl_oe);
   wire logic sda_line = ~(sda_low | sda_oe);
   // Locations 0xE0 to 0xEF are left unimplemented
   wire logic reg_valid = reg_ptr[7:4] != 4'hE;
   wire logic [7:0] reg_rdata = reg_valid ? mem[reg_ptr] : 8'h00;

   always #2 ref_clk = ~ref_clk;

   initial begin
      for (int i = 0; i < 256; i++)
         mem[i] = (8'(i) == 8'h20) ? 8'hFF : 8'(i) ^ 8'hA5;
   end

   // Bank side: log writes, watch for any push-high drive
   always @(posedge ref_clk) begin
      if (scl_oe === 1'b1 || (sda_oe === 1'b1 && sda_o !== 1'b0))
         bad_drive <= 1'b1;
      if (reg_we === 1'b1) begin
         wq.push_back({reg_waddr, reg_wdata});
         if (reg_waddr[7:4] != 4'hE)
            mem[reg_waddr] <= reg_wdata;
      end
   end

   // Expected bank contents; written places are never read back
   function automatic logic [7:0] ev(input logic [7:0] i);
      if (i[7:4] == 4'hE)
         return 8'h00;
      return (i == 8'h20) ? 8'hFF : i ^ 8'hA5;
   endfunction

   i2t_target dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
      .bias_power_good(bias_power_good), .strap_code(strap_code),
      .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe(sda_oe), .reg_ptr(reg_ptr),
      .reg_rdata(reg_rdata), .reg_valid(reg_valid), .reg_we(reg_we),
      .reg_waddr(reg_waddr), .reg_wdata(reg_wdata),
      .target_addr(target_addr), .clk_role(clk_role),
      .strap_done(strap_done));

   i2t_host_model host_u (.ref_clk(ref_clk), .sda_line(sda_line),
      .scl_low(scl_low), .sda_low(sda_low));

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic do_reset(input logic [2:0] c);
      rst_n <= 1'b0;
      bias_power_good <= 1'b0;
      strap_code <= c;
      tick(12);
      rst_n <= 1'b1;
      tick(2);
   endtask

   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Expected clock role per strap code; codes 6 and 7 count as open
   function automatic logic [1:0] exp_role(input int c);
      case (c)
         0: return 2'h0;
         1, 3: return 2'h1;
         2, 4: return 2'h2;
         default: return 2'h3;
      endcase
   endfunction

   task automatic t_strap();
      logic [6:0] ea;
      for (int c = 0; c < 8; c++) begin
         ea = 7'h08 + 7'((c > 5) ? 5 : c);
         do_reset(3'(c));
         `CHK("strap_done", 1'b0, strap_done)
         bias_power_good <= 1'b1;
         tick(8);
         `CHK("target_addr", ea, target_addr)
         `CHK("clk_role", exp_role(c), clk_role)
         strap_code <= 3'(5 - c);
         tick(8);
         `CHK("addr_held", ea, target_addr)
         `CHK("role_held", exp_role(c), clk_role)
      end
      $display("t_strap done");
   endtask

   // Traffic while bias is not good must get no acknowledge
   task automatic t_silent();
      logic ack;
      do_reset(3'h2);
      host_u.bus_start();
      host_u.send_byte({ADDR, 1'b0}, ack);
      `CHK("ack_no_bias", 1'b0, ack)
      host_u.bus_stop();
      bias_power_good <= 1'b1;
      tick(8);
      `CHK("strap_done", 1'b1, strap_done)
      $display("t_silent done");
   endtask

   task automatic wr_seq(input logic [7:0] idx, input int n,
                         input logic [7:0] d0);
      logic ack;
      logic [15:0] exp_w;
      wq.delete();
      host_u.bus_start();
      host_u.send_byte({ADDR, 1'b0}, ack);
      `CHK("ack_addr_w", 1'b1, ack)
      host_u.send_byte(idx, ack);
      `CHK("ack_index", 1'b1, ack)
      `CHK("ptr_loaded", idx, reg_ptr)
      for (int k = 0; k < n; k++) begin
         host_u.send_byte(d0 + 8'(k), ack);
         `CHK("ack_data", 1'b1, ack)
      end
      host_u.bus_stop();
      `CHK("write_count", n, wq.size())
      // Expected word built first: a brace list inside a macro argument
      // is not split safely by every simulator
      for (int k = 0; k < n; k++) begin
         exp_w = {idx + 8'(k), d0 + 8'(k)};
         `CHK("write", exp_w, wq[k])
      end
      `CHK("ptr_after_write", idx + 8'(n), reg_ptr)
   endtask

   task automatic rd_seq(input logic set, input logic [7:0] idx, input int n);
      logic ack;
      logic [7:0] b;
      if (set) begin
         host_u.bus_start();
         host_u.send_byte({ADDR, 1'b0}, ack);
         host_u.send_byte(idx, ack);
         `CHK("ack_index_r", 1'b1, ack)
      end
      host_u.bus_start();
      host_u.send_byte({ADDR, 1'b1}, ack);
      `CHK("ack_addr_r", 1'b1, ack)
      for (int k = 0; k < n; k++) begin
         host_u.recv_byte(k < n - 1, b);
         `CHK("read_data", ev(idx + 8'(k)), b)
      end
      host_u.bus_stop();
      `CHK("ptr_after_read", idx + 8'(n), reg_ptr)
   endtask

   task automatic t_write();
      wr_seq(8'h30, 3, 8'hC0);
      wr_seq(8'hFF, 2, 8'h11);
      $display("t_write done");
   endtask

   task automatic t_read();
      logic ack;
      rd_seq(1'b1, 8'h10, 1);
      host_u.bus_start();
      host_u.send_byte({7'h20, 1'b0}, ack);
      `CHK("ack_foreign", 1'b0, ack)
      host_u.send_byte(8'h55, ack);
      host_u.bus_stop();
      `CHK("ptr_kept", 8'h11, reg_ptr)
      rd_seq(1'b0, 8'h11, 1);
      rd_seq(1'b1, 8'hDF, 3);
      $display("t_read done");
   endtask

   // Byte at 0x20 is all ones, so SDA stays free for the early STOP
   task automatic t_abort();
      logic ack;
      logic s;
      host_u.bus_start();
      host_u.send_byte({ADDR, 1'b0}, ack);
      host_u.send_byte(8'h20, ack);
      host_u.bus_start();
      host_u.send_byte({ADDR, 1'b1}, ack);
      for (int k = 0; k < 4; k++)
         host_u.clk_bit(1'b1, s);
      `CHK("ptr_before_fifth", 8'h20, reg_ptr)
      host_u.clk_bit(1'b1, s);
      `CHK("ptr_at_fifth", 8'h21, reg_ptr)
      host_u.bus_stop();
      `CHK("ptr_after_abort", 8'h21, reg_ptr)
      rd_seq(1'b0, 8'h21, 1);
      $display("t_abort done");
   endtask

   initial begin
      t_strap();
      t_silent();
      t_write();
      t_read();
      t_abort();
      `CHK("open_drain", 1'b0, bad_drive)
      wrap_up();
   end

   // Tests need about 5000 clocks; this allows fifteen times that
   initial begin
      #300000;
      n_errors++;
      wrap_up();
   end
endmodule // test_i2t_target
